// ==== design/ltrcfg_regs_top.v ====
// config-space registers for latency tolerance reporting of one function
// Functional notes
// - endpoint buffers requests, bursts at full bandwidth
// - support bit 11 reads one when supported
// - all upstream functions report same support
// - bridges, downstream ports tie support zero
// - control bit 10 enables reporting
// - upstream: only function zero has writable enable; every downstream function has one
// - unsupported component may tie enable zero
// - enable resets to zero
// - downstream port clears enable on link down
// - extended capability only on supporting upstream ports
// - extended capability only in function zero
// - header id reads 0018h
// - header version reads 1h
// - header next pointer is configured offset
// - snoop at 04h, no-snoop at 06h
// - bits 9:0 writable latency value
// - bits 12:10 writable latency scale
// - value and scale reset to zero
// - switch reports only while upstream enable set
// - downstream enable clear invalidates its tolerances
`timescale 1ns/1ps
`include "ltrcfg_regs.vh"
module ltrcfg_regs_top #(
   parameter       LTR_SUPPORTED = 1,
   parameter       IS_DOWNSTREAM = 0,
   parameter       IS_BRIDGE     = 0,
   parameter [2:0] FUNC_NUM      = 3'h0,
   parameter [11:0] CAP_BASE     = 12'h100,
   parameter [11:0] NEXT_CAP     = `LTRCFG_NEXT_NONE
) (
   // clock and reset
   input  wire        mclk_in,
   input  wire        reset_n_in,
   // configuration access from the root complex
   input  wire        cfg_req_in,
   input  wire        cfg_wr_in,
   input  wire [11:0] cfg_addr_in,
   input  wire [3:0]  cfg_be_in,
   input  wire [31:0] cfg_wdata_in,
   output reg  [31:0] cfg_rdata_out,
   output reg         cfg_ack_out,
   output reg         cfg_hit_out,
   // link status
   input  wire        dl_down_in,
   // requested tolerances from the function core
   input  wire [12:0] req_snoop_in,
   input  wire [12:0] req_nosnoop_in,
   input  wire        req_update_in,
   // state to the message logic
   output wire        ltr_enable_out,
   output reg  [12:0] rpt_snoop_out,
   output reg  [12:0] rpt_nosnoop_out,
   output reg         rpt_send_out,
   output wire        tol_invalid_out
);

   // structural qualifiers, evaluated at elaboration
   // these are constants, so a function without the feature spends no gates on it
   // tie on bridges
   localparam SUP_BIT = (LTR_SUPPORTED != 0) && (IS_BRIDGE == 0);
   localparam SUP_ADV = SUP_BIT && (IS_DOWNSTREAM == 0);
   // only function zero of an upstream port owns the enable
   localparam EN_RW   = (LTR_SUPPORTED != 0) && (IS_DOWNSTREAM != 0 || FUNC_NUM == 3'h0);
   // and only function zero carries it
   localparam HAS_CAP = (LTR_SUPPORTED != 0) && (IS_DOWNSTREAM == 0) && (FUNC_NUM == 3'h0);

   // byte addresses of the decoded dwords; only bits 11:2 take part in a match
   // the no-snoop register shares the dword of the snoop register, so it has no entry here
   localparam [11:0] DEVCAP2_ADR = `LTRCFG_DEVCAP2_OFF;
   localparam [11:0] DEVCTL2_ADR = `LTRCFG_DEVCTL2_OFF;
   localparam [11:0] HDR_ADR     = CAP_BASE + `LTRCFG_CAP_HDR_REL;
   localparam [11:0] LAT_ADR     = CAP_BASE + `LTRCFG_MAXLAT_REL;
   // writable bits of one maximum latency field; the rest read zero
   localparam [15:0] FLD_MASK    = `LTRCFG_LAT_FIELD_MASK;

   // dword match of a request address; the byte offset inside the dword is ignored
   // a capability placed off a dword boundary would alias, so CAP_BASE must be aligned
   function dw_hit;
      input [11:0] addr;
      input [11:0] reg_adr;
      begin
         dw_hit = (addr[11:2] == reg_adr[11:2]);
      end
   endfunction

   // latency is compared after expansion; scale steps are 32x
   function [47:0] lat_ns;
      input [12:0] f;
      begin
         lat_ns = {38'h0, f[9:0]} << (5 * f[12:10]);
      end
   endfunction

   // pick the smaller of a request and its ceiling
   function [12:0] lat_clamp;
      input [12:0] req;
      input [12:0] ceil;
      begin
         if (lat_ns(req) > lat_ns(ceil)) begin
            lat_clamp = ceil;
         end else begin
            lat_clamp = req;
         end
      end
   endfunction

   reg         enable;
   wire [12:0] max_snoop;
   wire [12:0] max_nosnoop;
   wire        cap_hdr_hit;
   wire        cap_lat_hit;
   wire        devcap2_hit;
   wire        devctl2_hit;
   wire        wr_cap;
   wire [12:0] wdata_fld;
   wire [12:0] wmask_fld;
   wire [12:0] wmask_ns_fld;
   wire        wr_snoop_en;
   wire        wr_nosnoop_en;

   // address decode; the capability dword holds both 16-bit registers
   // place snoop, no-snoop
   assign devcap2_hit = dw_hit(cfg_addr_in, DEVCAP2_ADR);
   assign devctl2_hit = dw_hit(cfg_addr_in, DEVCTL2_ADR);
   // capability dwords vanish from the map where the structure is not carried
   assign cap_hdr_hit = HAS_CAP && dw_hit(cfg_addr_in, HDR_ADR);
   assign cap_lat_hit = HAS_CAP && dw_hit(cfg_addr_in, LAT_ADR);

   // byte lanes 0-1 hit snoop, 2-3 hit no-snoop; both may be written at once
   assign wr_cap    = cfg_req_in && cfg_wr_in && cap_lat_hit;
   assign wdata_fld = cfg_wdata_in[12:0];
   assign wmask_fld = {{5{cfg_be_in[1]}}, {8{cfg_be_in[0]}}} & FLD_MASK[12:0];
   assign wmask_ns_fld = {{5{cfg_be_in[3]}}, {8{cfg_be_in[2]}}} & FLD_MASK[12:0];

   // a half is only touched when one of its own byte lanes is enabled
   assign wr_snoop_en   = wr_cap && (cfg_be_in[1:0] != 2'b00);
   assign wr_nosnoop_en = wr_cap && (cfg_be_in[3:2] != 2'b00);

   ltrcfg_maxlat_store #(
      .WIDTH (13)
   ) u_store_snoop (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (wr_snoop_en),
      .wr_sel_in   (1'b0),
      .wr_data_in  (wdata_fld),
      .wr_mask_in  (wmask_fld),
      .snoop_out   (max_snoop),
      .nosnoop_out ()
   );

   // second instance takes the upper lanes of the same dword
   ltrcfg_maxlat_store #(
      .WIDTH (13)
   ) u_store_nosnoop (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (wr_nosnoop_en),
      .wr_sel_in   (1'b1),
      .wr_data_in  (cfg_wdata_in[28:16]),
      .wr_mask_in  (wmask_ns_fld),
      .snoop_out   (),
      .nosnoop_out (max_nosnoop)
   );

   // enable bit, cleared by reset and by link down on downstream ports
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enable <= `LTRCFG_ENABLE_RST;
      end else if ((IS_DOWNSTREAM != 0) && dl_down_in) begin
         enable <= `LTRCFG_ENABLE_RST;
      end else if (EN_RW && cfg_req_in && cfg_wr_in && devctl2_hit && cfg_be_in[1]) begin
         enable <= cfg_wdata_in[`LTRCFG_ENABLE_BIT];
      end
   end

   assign ltr_enable_out = EN_RW ? enable : 1'b0;

   assign tol_invalid_out = (IS_DOWNSTREAM != 0) && !ltr_enable_out;

   // read mux and single-cycle acknowledge
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_rdata_out <= 32'h00000000;
         cfg_ack_out   <= 1'b0;
         cfg_hit_out   <= 1'b0;
      end else begin
         cfg_ack_out   <= cfg_req_in;
         cfg_hit_out   <= cfg_req_in && (devcap2_hit || devctl2_hit || cap_hdr_hit || cap_lat_hit);
         cfg_rdata_out <= 32'h00000000;
         if (cfg_req_in && !cfg_wr_in) begin
            if (devcap2_hit) begin
               cfg_rdata_out[`LTRCFG_SUPPORT_BIT] <= SUP_ADV ? 1'b1 : 1'b0;
            end else if (devctl2_hit) begin
               cfg_rdata_out[`LTRCFG_ENABLE_BIT] <= ltr_enable_out;
            end else if (cap_hdr_hit) begin
               cfg_rdata_out <= {NEXT_CAP, `LTRCFG_CAP_VERSION, `LTRCFG_CAP_ID};
            end else if (cap_lat_hit) begin
               cfg_rdata_out <= {3'h0, max_nosnoop, 3'h0, max_snoop};
            end
         end
      end
   end

   // report held for burst
   // the last report stands until the next update, so the message logic may batch it
   // reported tolerances: clamped to the programmed maxima, sent only when enabled
   // a zero maximum means unprogrammed, so no clamp is applied then
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rpt_snoop_out   <= 13'h0000;
         rpt_nosnoop_out <= 13'h0000;
         rpt_send_out    <= 1'b0;
      end else begin
         rpt_send_out <= req_update_in && ltr_enable_out;
         if (req_update_in && ltr_enable_out) begin
            rpt_snoop_out   <= (max_snoop == 13'h0000) ? req_snoop_in
                               : lat_clamp(req_snoop_in, max_snoop);
            rpt_nosnoop_out <= (max_nosnoop == 13'h0000) ? req_nosnoop_in
                               : lat_clamp(req_nosnoop_in, max_nosnoop);
         end
      end
   end
endmodule // ltrcfg_regs_top

// ==== design/ltrcfg_regs.vh ====
// offsets, field positions, reset values and constants of the latency tolerance config registers
`ifndef LTRCFG_REGS_VH
`define LTRCFG_REGS_VH
// byte addresses within the config space view of this block; decode compares bits 11:2
`define LTRCFG_DEVCAP2_OFF      12'h024
`define LTRCFG_DEVCTL2_OFF      12'h028
`define LTRCFG_CAP_HDR_REL      12'h000
`define LTRCFG_MAXLAT_REL       12'h004
`define LTRCFG_MAXNS_REL        12'h006
// field positions
`define LTRCFG_SUPPORT_BIT      11
`define LTRCFG_ENABLE_BIT       10
`define LTRCFG_LAT_VALUE_MSB    9
`define LTRCFG_LAT_SCALE_LSB    10
`define LTRCFG_LAT_SCALE_MSB    12
`define LTRCFG_LAT_FIELD_MASK   16'h1fff
// fixed header contents
`define LTRCFG_CAP_ID           16'h0018
`define LTRCFG_CAP_VERSION      4'h1
`define LTRCFG_NEXT_NONE        12'h000
// reset values
`define LTRCFG_ENABLE_RST       1'b0
`define LTRCFG_MAXLAT_RST       13'h0000
`endif

// ==== design/ltrcfg_maxlat_store.v ====
// two-entry store holding the snoop and no-snoop maximum latency fields
`timescale 1ns/1ps
`include "ltrcfg_regs.vh"
module ltrcfg_maxlat_store #(
   parameter WIDTH = 13
) (
   // clock and reset
   input  wire             mclk_in,
   input  wire             reset_n_in,
   // write port, one entry per write
   input  wire             wr_en_in,
   input  wire             wr_sel_in,
   input  wire [WIDTH-1:0] wr_data_in,
   input  wire [WIDTH-1:0] wr_mask_in,
   // registered read of both entries
   output reg  [WIDTH-1:0] snoop_out,
   output reg  [WIDTH-1:0] nosnoop_out
);

   // masked update; entry 0 is snoop, entry 1 is no-snoop
   // fields reset zero
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         snoop_out   <= `LTRCFG_MAXLAT_RST;
         nosnoop_out <= `LTRCFG_MAXLAT_RST;
      end else if (wr_en_in) begin
         if (wr_sel_in) begin
            nosnoop_out <= (nosnoop_out & ~wr_mask_in) | (wr_data_in & wr_mask_in);
         end else begin
            snoop_out <= (snoop_out & ~wr_mask_in) | (wr_data_in & wr_mask_in);
         end
      end
   end
endmodule // ltrcfg_maxlat_store

// ==== test/ltrcfg_regs_chk_asserts.sv ====
// checker of config access timing and latency register contents
`timescale 1ns/1ps
module ltrcfg_regs_chk (
   // watched ports
   input wire        mclk_in,
   input wire        reset_n_in,
   input wire        cfg_req_in,
   input wire        cfg_wr_in,
   input wire [11:0] cfg_addr_in,
   input wire [3:0]  cfg_be_in,
   input wire [31:0] cfg_wdata_in,
   input wire [31:0] cfg_rdata_out,
   input wire        cfg_ack_out,
   input wire        req_update_in,
   input wire        ltr_enable_out,
   input wire        rpt_send_out,
   input wire        tol_invalid_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   // request steps: a read at one address, an enable write with its byte lane
   sequence rd_at(a); cfg_req_in && !cfg_wr_in && cfg_addr_in == a; endsequence
   sequence wr_en; cfg_req_in && cfg_wr_in && cfg_addr_in == 12'h028 && cfg_be_in[1]; endsequence
   ack_next_a: assert property (cfg_req_in |=> cfg_ack_out) else $error("no ack after request");
   ack_cause_a: assert property (cfg_ack_out |-> $past(cfg_req_in)) else $error("stray ack");
   rdata_idle_a: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0) else $error("idle data");
   hdr_value_a: assert property (rd_at(12'h100) |=>
      cfg_rdata_out == 32'h00010018) else $error("bad capability header");
   support_bit_a: assert property (rd_at(12'h024) |=> cfg_rdata_out[11])
      else $error("support bit clear");
   ctl_read_a: assert property (rd_at(12'h028) |=> cfg_rdata_out[10] == $past(ltr_enable_out))
      else $error("enable read mismatch");
   rsvd_zero_a: assert property (rd_at(12'h104) |=>
      cfg_rdata_out[15:13] == 3'h0 && cfg_rdata_out[31:29] == 3'h0) else $error("reserved set");
   enable_wr_a: assert property (wr_en |=> ltr_enable_out == $past(cfg_wdata_in[10]))
      else $error("enable write lost");
   send_gate_a: assert property (req_update_in |=> rpt_send_out == $past(ltr_enable_out))
      else $error("send not gated by enable");
   tol_valid_a: assert property (!tol_invalid_out) else $error("upstream tolerance invalid");
endmodule // ltrcfg_regs_chk
bind ltrcfg_regs_top ltrcfg_regs_chk u_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
   .cfg_req_in(cfg_req_in), .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in),
   .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
   .cfg_ack_out(cfg_ack_out), .req_update_in(req_update_in), .ltr_enable_out(ltr_enable_out),
   .rpt_send_out(rpt_send_out), .tol_invalid_out(tol_invalid_out));

// ==== test/ltrcfg_rc_model.sv ====
// root complex model issuing one config request at a time
`timescale 1ns/1ps
module ltrcfg_rc_model (
   // clock and answer
   input  wire        mclk_in,
   input  wire        cfg_ack_in,
   input  wire        cfg_hit_in,
   input  wire [31:0] cfg_rdata_in,
   // request lines
   output reg         cfg_req_out,
   output reg         cfg_wr_out,
   output reg  [11:0] cfg_addr_out,
   output reg  [3:0]  cfg_be_out,
   output reg  [31:0] cfg_wdata_out
);
   initial {cfg_req_out, cfg_wr_out, cfg_addr_out, cfg_be_out, cfg_wdata_out} = 49'h0;
   // one-cycle request pulse, answer taken at the edge that sees ack
   task access(input w, input [11:0] a, input [3:0] b, input [31:0] d,
               output [31:0] q, output h, output ok);
      integer n;
      begin
         @(posedge mclk_in);
         {cfg_req_out, cfg_wr_out, cfg_addr_out, cfg_be_out, cfg_wdata_out} <= {1'b1, w, a, b, d};
         @(posedge mclk_in);
         // released lines flip so stale values are never mistaken for live ones
         {cfg_req_out, cfg_wr_out, cfg_addr_out, cfg_be_out, cfg_wdata_out} <= {1'b0, ~w, ~a, ~b, ~d};
         ok = 1'b0;
         for (n = 0; n < 4 && !ok; n = n + 1) begin
            @(posedge mclk_in);
            ok = (cfg_ack_in === 1'b1);
         end
         q = cfg_rdata_in;
         h = cfg_hit_in;
      end
   endtask
endmodule // ltrcfg_rc_model

// ==== test/ltrcfg_regs_top_tb.sv ====
// self-checking bench of the latency tolerance config registers
`timescale 1ns/1ps
module ltrcfg_regs_top_tb;
   reg         mclk_in, reset_n_in, dl_down_in, req_update_in;
   reg  [12:0] req_snoop_in, req_nosnoop_in;
   wire        cfg_req_in, cfg_wr_in, cfg_ack_out, cfg_hit_out, ltr_enable_out;
   wire        rpt_send_out, tol_invalid_out;
   wire [11:0] cfg_addr_in;
   wire [3:0]  cfg_be_in;
   wire [31:0] cfg_wdata_in, cfg_rdata_out;
   wire [12:0] rpt_snoop_out, rpt_nosnoop_out;
   reg  [31:0] q;
   reg         h, ok;
   integer     errors, checks;
   ltrcfg_regs_top dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_req_in(cfg_req_in),
      .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
      .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
      .cfg_hit_out(cfg_hit_out), .dl_down_in(dl_down_in), .req_snoop_in(req_snoop_in),
      .req_nosnoop_in(req_nosnoop_in), .req_update_in(req_update_in),
      .ltr_enable_out(ltr_enable_out), .rpt_snoop_out(rpt_snoop_out),
      .rpt_nosnoop_out(rpt_nosnoop_out), .rpt_send_out(rpt_send_out),
      .tol_invalid_out(tol_invalid_out));
   ltrcfg_rc_model rc (.mclk_in(mclk_in), .cfg_ack_in(cfg_ack_out), .cfg_hit_in(cfg_hit_out),
      .cfg_rdata_in(cfg_rdata_out), .cfg_req_out(cfg_req_in), .cfg_wr_out(cfg_wr_in),
      .cfg_addr_out(cfg_addr_in), .cfg_be_out(cfg_be_in), .cfg_wdata_out(cfg_wdata_in));
   // 250 MHz clock
   always #2 mclk_in = ~mclk_in;
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (errors == 0 && checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // a lost answer ends the run at once
   task acc(input w, input [11:0] a, input [3:0] b, input [31:0] d);
      begin
         rc.access(w, a, b, d, q, h, ok);
         if (!ok) begin
            errors = errors + 1;
            report_and_stop;
         end
      end
   endtask
   task t_reset;
      begin
         acc(1'b0, 12'h028, 4'h0, 32'h0);
         check(q[10], 1'b0);
         check(ltr_enable_out, 1'b0);
         acc(1'b0, 12'h104, 4'h0, 32'h0);
         check(q, 32'h0);
      end
   endtask
   task t_header;
      begin
         acc(1'b0, 12'h100, 4'h0, 32'h0);
         check(q, 32'h00010018);
         check(h, 1'b1);
         acc(1'b0, 12'h024, 4'h0, 32'h0);
         check(q[11], 1'b1);
         acc(1'b0, 12'h200, 4'h0, 32'h0);
         check(h, 1'b0);
         check(q, 32'h0);
      end
   endtask
   // maxima programmed by software, partial lane write second
   task t_maxlat;
      begin
         acc(1'b1, 12'h104, 4'hf, 32'hffffffff);
         acc(1'b0, 12'h104, 4'h0, 32'h0);
         check(q, 32'h1fff1fff);
         acc(1'b1, 12'h104, 4'h3, 32'h12345678);
         acc(1'b0, 12'h104, 4'h0, 32'h0);
         check(q, 32'h1fff1678);
      end
   endtask
   task t_enable;
      begin
         acc(1'b1, 12'h028, 4'h1, 32'h400);
         check(ltr_enable_out, 1'b0);
         acc(1'b1, 12'h028, 4'h2, 32'h400);
         acc(1'b0, 12'h028, 4'h0, 32'h0);
         check(q[10], 1'b1);
         dl_down_in <= 1'b1;
         repeat (2) @(posedge mclk_in);
         check(ltr_enable_out, 1'b1);
         check(tol_invalid_out, 1'b0);
         dl_down_in <= 1'b0;
      end
   endtask
   // request beyond the snoop maximum is clamped, then sending stops when disabled
   task t_clamp(input en);
      begin
         req_snoop_in <= 13'h1fff;
         req_nosnoop_in <= 13'h0001;
         req_update_in <= 1'b1;
         @(posedge mclk_in);
         req_update_in <= 1'b0;
         @(posedge mclk_in);
         check(rpt_send_out, en);
         if (en) check({rpt_snoop_out, rpt_nosnoop_out}, {13'h1678, 13'h0001});
      end
   endtask
   initial begin
      {mclk_in, reset_n_in, dl_down_in, req_update_in} = 4'h0;
      {req_snoop_in, req_nosnoop_in} = 26'h0;
      errors = 0;
      checks = 0;
      repeat (8) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      t_reset;
      t_header;
      t_maxlat;
      t_enable;
      t_clamp(1'b1);
      acc(1'b1, 12'h028, 4'h2, 32'h0);
      t_clamp(1'b0);
      report_and_stop;
   end
endmodule // ltrcfg_regs_top_tb
